// File: logic/ugc_pkg.sv
// Purpose: Shared constants and types of the USB global control block
// Assumes: 8-bit register port, 125 MHz system clock
// Notes:   Offsets are byte addresses on the plain register port
`default_nettype none

package ugc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_CONTROL  = 8'hbc;
  localparam logic [7:0] OFS_FLAGS    = 8'hbd;
  localparam logic [7:0] OFS_FLAG_EN  = 8'hbe;
  localparam logic [7:0] OFS_PRIO     = 8'hbf;
  localparam logic [7:0] OFS_EP_BASE  = 8'hc0;
  localparam logic [7:0] OFS_EP_EN    = 8'hc8;

  // Global control fields
  localparam int CTL_ENABLE   = 7;
  localparam int CTL_CLK_SUSP = 6;
  localparam int CTL_RWU_SEND = 5;
  localparam int CTL_DETACH   = 4;
  localparam int CTL_URSM     = 3;
  localparam int CTL_RWU_EN   = 2;
  localparam int CTL_CONFIG   = 1;
  localparam int CTL_ADDR_EN  = 0;
  localparam logic [7:0] CTL_RESET    = 8'h00;
  localparam logic [7:0] CTL_WR_MASK  = 8'hf7;

  // Global flag fields
  localparam int FLG_WAKE    = 5;
  localparam int FLG_BUS_RST = 4;
  localparam int FLG_SOF     = 3;
  localparam int FLG_SUSP    = 0;
  localparam logic [7:0] FLG_MASK = 8'h39;

  // Endpoint flag fields
  localparam int EPF_TX_DONE  = 0;
  localparam int EPF_RX_BANK0 = 1;
  localparam int EPF_SETUP    = 2;
  localparam int EPF_STALL    = 3;
  localparam int EPF_RX_BANK1 = 6;

  // Priority fields
  localparam int PRI_LOW  = 0;
  localparam int PRI_HIGH = 1;

  // Timing
  localparam int CLK_MHZ          = 125;
  localparam int IDLE_SUSP_US     = 3000;
  localparam int SUSP_MIN_US      = 5000;
  localparam int RESUME_DRIVE_US  = 10000;
  localparam int IDLE_SUSP_CYC    = IDLE_SUSP_US * CLK_MHZ;
  localparam int SUSP_MIN_CYC     = SUSP_MIN_US * CLK_MHZ;
  localparam int RESUME_DRIVE_CYC = RESUME_DRIVE_US * CLK_MHZ;
  localparam int TIMER_W          = 22;

  typedef enum logic [2:0] {
    UGC_LINK_RUN     = 3'b001,
    UGC_LINK_SUSPEND = 3'b010,
    UGC_LINK_RESUME  = 3'b100
  } ugc_link_t;

endpackage

`default_nettype wire

// File: logic/ugc_timer.sv
// Purpose: Continuous-run cycle timer with a sticky reached output
// Assumes: run held high for the whole interval being timed
// Notes:   Dropping run restarts the count from zero
`default_nettype none

module ugc_timer #(
  parameter int LIMIT = 16,
  parameter int CW    = ugc_pkg::TIMER_W
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic run,
  output var  logic reached
);

  localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
  localparam logic [CW-1:0] ONE_C   = CW'(1);

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      reached <= 1'b0;
    end else if (!run) begin
      cnt_reg <= '0;
      reached <= 1'b0;
    end else if (cnt_reg != LIMIT_C) begin
      cnt_reg <= cnt_reg + ONE_C;
      reached <= (cnt_reg + ONE_C) == LIMIT_C;
    end
  end

endmodule

`default_nettype wire

// File: logic/ugc_global_ctrl.sv
// Purpose: USB global control, bus event flags and common interrupt request
// Assumes: SIE event inputs are one-cycle pulses on clk; line state is a pin
// Notes:   Register port answers reads one cycle later, never stalls
//
// Functional notes
// - Detach bit set floats the pull-up reference output.
// - Detach bit cleared drives the pull-up reference high again.
// - Two priority bits encode level 0 lowest to 3 highest.
// - Host ack of an IN packet sets that endpoint's transmit-complete flag.
// - OUT packet stored in bank 0 sets the bank 0 receive flag.
// - Bank 1 receive flag set only on ping-pong endpoints.
// - Accepted SETUP packet sets the endpoint setup-received flag.
// - Stall-sent flag set after STALL, cleared by SETUP; not isochronous.
// - Each received start-of-frame packet sets the frame-start flag.
// - Resume activity while suspended sets the CPU wake flag.
// - Detected bus suspend sets the suspend flag.
// - All endpoint and bus flags feed one common interrupt request.
// - Enable bit clear resets controller, transceiver off, clocks gated.
// - Clock suspend gates controller clock; resume detection keeps working.
// - Upstream resume needs wakeup enable, clocks running, 5 ms suspended.
// - Flags register: wake bit 5, bus reset 4, frame 3, suspend 0.
// - Upstream resume status set while signalling, cleared when done.
// - Suspend declared after more than 3 ms idle bus.
//
// The address-and-strobe port was left to the implementer.
`default_nettype none

module ugc_global_ctrl #(
  parameter int          NUM_EP        = 7,
  parameter logic [6:0]  PINGPONG_MASK = 7'h30,
  parameter int          IDLE_CYC      = ugc_pkg::IDLE_SUSP_CYC,
  parameter int          SUSP_CYC      = ugc_pkg::SUSP_MIN_CYC,
  parameter int          RESUME_CYC    = ugc_pkg::RESUME_DRIVE_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic [ugc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ugc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output var  logic [ugc_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [NUM_EP-1:0]         ev_in_acked,
  input  wire logic [NUM_EP-1:0]         ev_out_bank0,
  input  wire logic [NUM_EP-1:0]         ev_out_bank1,
  input  wire logic [NUM_EP-1:0]         ev_setup,
  input  wire logic [NUM_EP-1:0]         ev_stall_sent,
  input  wire logic [NUM_EP-1:0]         ep_is_iso,
  input  wire logic                      ev_sof,
  input  wire logic                      ev_bus_reset_end,
  input  wire logic                      line_idle_pin,
  output var  logic                      vref_out,
  output var  logic                      vref_oe_b,
  output var  logic                      usb_clk_en,
  output var  logic                      xcvr_en,
  output var  logic                      ctrl_rst_b,
  output var  logic                      resume_drive,
  output var  logic                      usb_irq,
  output var  logic [1:0]                usb_prio_level
);

  logic [7:0]            control_reg;
  logic [7:0]            flags_reg;
  logic [7:0]            flag_en_reg;
  logic [1:0]            prio_reg;
  logic [NUM_EP-1:0]     ep_en_reg;
  logic [7:0]            ep_flags_reg [NUM_EP];
  ugc_pkg::ugc_link_t    link_reg;
  ugc_pkg::ugc_link_t    link_next;
  logic                  idle_s1_reg;
  logic                  idle_s2_reg;
  logic                  served_reg;
  logic                  idle_done;
  logic                  susp_done;
  logic                  rsm_done;
  logic                  ctl_on;
  logic                  clk_run;
  logic                  rsm_start;
  logic                  wr_ctl;
  logic                  wr_flags;
  logic [NUM_EP-1:0]     wr_ep;
  logic [NUM_EP-1:0]     ep_pend;
  logic [7:0]            flags_set;
  logic [7:0]            ep_rd;

  assign ctl_on   = control_reg[ugc_pkg::CTL_ENABLE];
  assign clk_run  = ctl_on & ~control_reg[ugc_pkg::CTL_CLK_SUSP];
  assign wr_ctl   = reg_wr && (reg_addr == ugc_pkg::OFS_CONTROL);
  assign wr_flags = reg_wr && (reg_addr == ugc_pkg::OFS_FLAGS);

  // Pin synchroniser for the bus idle level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_s1_reg <= 1'b1;
      idle_s2_reg <= 1'b1;
    end else begin
      idle_s1_reg <= line_idle_pin;
      idle_s2_reg <= idle_s1_reg;
    end
  end

  // Idle bus timer runs only with all clocks enabled
  ugc_timer #(
    .LIMIT (IDLE_CYC)
  ) u_idle_timer (
    .clk     (clk),
    .rst_b   (rst_b),
    .run     (clk_run && idle_s2_reg && (link_reg == ugc_pkg::UGC_LINK_RUN)),
    .reached (idle_done)
  );

  // Time spent suspended, for the remote wakeup minimum
  ugc_timer #(
    .LIMIT (SUSP_CYC)
  ) u_susp_timer (
    .clk     (clk),
    .rst_b   (rst_b),
    .run     (link_reg == ugc_pkg::UGC_LINK_SUSPEND),
    .reached (susp_done)
  );

  // Length of the upstream resume signalling
  ugc_timer #(
    .LIMIT (RESUME_CYC)
  ) u_rsm_timer (
    .clk     (clk),
    .rst_b   (rst_b),
    .run     (link_reg == ugc_pkg::UGC_LINK_RESUME),
    .reached (rsm_done)
  );

  // One resume per request; rearmed only when firmware drops the bit
  assign rsm_start = (link_reg == ugc_pkg::UGC_LINK_SUSPEND)
                   && control_reg[ugc_pkg::CTL_RWU_SEND] && !served_reg
                   && control_reg[ugc_pkg::CTL_RWU_EN] && clk_run && susp_done;

  always_comb begin
    link_next = link_reg;
    if (!ctl_on) begin
      link_next = ugc_pkg::UGC_LINK_RUN;
    end else begin
      case (link_reg)
        ugc_pkg::UGC_LINK_RUN: begin
          if (idle_done) begin
            link_next = ugc_pkg::UGC_LINK_SUSPEND;
          end
        end
        ugc_pkg::UGC_LINK_SUSPEND: begin
          // Resume detection does not depend on the clock suspend bit
          if (!idle_s2_reg) begin
            link_next = ugc_pkg::UGC_LINK_RUN;
          end else if (rsm_start) begin
            link_next = ugc_pkg::UGC_LINK_RESUME;
          end
        end
        ugc_pkg::UGC_LINK_RESUME: begin
          if (rsm_done) begin
            link_next = ugc_pkg::UGC_LINK_RUN;
          end
        end
        default: begin
          link_next = ugc_pkg::UGC_LINK_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_reg <= ugc_pkg::UGC_LINK_RUN;
    end else begin
      link_reg <= link_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      served_reg <= 1'b0;
    end else if (!control_reg[ugc_pkg::CTL_RWU_SEND]) begin
      served_reg <= 1'b0;
    end else if (rsm_start) begin
      served_reg <= 1'b1;
    end
  end

  // Control register; the send bit is left for firmware to clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      control_reg <= ugc_pkg::CTL_RESET;
    end else begin
      if (wr_ctl) begin
        control_reg <= (reg_wdata & ugc_pkg::CTL_WR_MASK)
                     | (control_reg & ~ugc_pkg::CTL_WR_MASK);
      end
      control_reg[ugc_pkg::CTL_URSM] <= (link_next == ugc_pkg::UGC_LINK_RESUME);
      if (ev_bus_reset_end && ctl_on) begin
        control_reg[ugc_pkg::CTL_CONFIG]  <= 1'b0;
        control_reg[ugc_pkg::CTL_ADDR_EN] <= 1'b0;
      end
    end
  end

  // Bus event sources; own resume signalling never counts as a wake
  always_comb begin
    flags_set = 8'h00;
    flags_set[ugc_pkg::FLG_SUSP]    = (link_reg == ugc_pkg::UGC_LINK_RUN)
                                    && idle_done && ctl_on;
    flags_set[ugc_pkg::FLG_WAKE]    = (link_reg == ugc_pkg::UGC_LINK_SUSPEND)
                                    && !idle_s2_reg && ctl_on;
    flags_set[ugc_pkg::FLG_SOF]     = ev_sof && clk_run;
    flags_set[ugc_pkg::FLG_BUS_RST] = ev_bus_reset_end && ctl_on;
  end

  // Writing zero clears a flag; a same-cycle event wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= 8'h00;
    end else if (!ctl_on) begin
      flags_reg <= 8'h00;
    end else if (wr_flags) begin
      flags_reg <= ((flags_reg & reg_wdata) | flags_set) & ugc_pkg::FLG_MASK;
    end else begin
      flags_reg <= (flags_reg | flags_set) & ugc_pkg::FLG_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_en_reg <= 8'h00;
      prio_reg    <= 2'b00;
      ep_en_reg   <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ugc_pkg::OFS_FLAG_EN) begin
        flag_en_reg <= reg_wdata & ugc_pkg::FLG_MASK;
      end
      if (reg_addr == ugc_pkg::OFS_PRIO) begin
        prio_reg <= {reg_wdata[ugc_pkg::PRI_HIGH], reg_wdata[ugc_pkg::PRI_LOW]};
      end
      if (reg_addr == ugc_pkg::OFS_EP_EN) begin
        ep_en_reg <= reg_wdata[NUM_EP-1:0];
      end
    end
  end

  // Per-endpoint sticky flags
  genvar ep;
  generate
    for (ep = 0; ep < NUM_EP; ep++) begin : g_ep
      logic [7:0] set_v;
      logic [7:0] keep_v;
      assign wr_ep[ep] = reg_wr && (reg_addr == ugc_pkg::OFS_EP_BASE + 8'(ep));
      always_comb begin
        set_v = 8'h00;
        set_v[ugc_pkg::EPF_TX_DONE]  = ev_in_acked[ep];
        set_v[ugc_pkg::EPF_RX_BANK0] = ev_out_bank0[ep];
        set_v[ugc_pkg::EPF_RX_BANK1] = ev_out_bank1[ep] && PINGPONG_MASK[ep];
        set_v[ugc_pkg::EPF_SETUP]    = ev_setup[ep];
        set_v[ugc_pkg::EPF_STALL]    = ev_stall_sent[ep] && !ep_is_iso[ep];
        keep_v = wr_ep[ep] ? (ep_flags_reg[ep] & reg_wdata) : ep_flags_reg[ep];
        if (ev_setup[ep]) begin
          keep_v[ugc_pkg::EPF_STALL] = 1'b0;
        end
      end
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ep_flags_reg[ep] <= 8'h00;
        end else if (!clk_run) begin
          // Controller held in reset or its clock gated off
          ep_flags_reg[ep] <= ctl_on ? ep_flags_reg[ep] : 8'h00;
        end else begin
          ep_flags_reg[ep] <= keep_v | set_v;
        end
      end
      assign ep_pend[ep] = ep_en_reg[ep] && (ep_flags_reg[ep] != 8'h00);
    end
  endgenerate

  // Read mux for the endpoint window
  always_comb begin
    ep_rd = 8'h00;
    for (int i = 0; i < NUM_EP; i++) begin
      if (reg_addr == ugc_pkg::OFS_EP_BASE + 8'(i)) begin
        ep_rd = ep_flags_reg[i];
      end
    end
  end

  // Read data in the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ugc_pkg::OFS_CONTROL: reg_rdata <= control_reg;
        ugc_pkg::OFS_FLAGS:   reg_rdata <= flags_reg & ugc_pkg::FLG_MASK;
        ugc_pkg::OFS_FLAG_EN: reg_rdata <= flag_en_reg;
        ugc_pkg::OFS_PRIO:    reg_rdata <= {6'h00, prio_reg};
        ugc_pkg::OFS_EP_EN:   reg_rdata <= 8'(ep_en_reg);
        default:              reg_rdata <= ep_rd;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Interrupt request and pin outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      usb_irq        <= 1'b0;
      usb_prio_level <= 2'b00;
    end else begin
      usb_irq        <= ((flags_reg & flag_en_reg) != 8'h00) || (ep_pend != '0);
      usb_prio_level <= prio_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vref_out     <= 1'b1;
      vref_oe_b    <= 1'b0;
      usb_clk_en   <= 1'b0;
      xcvr_en      <= 1'b0;
      ctrl_rst_b   <= 1'b0;
      resume_drive <= 1'b0;
    end else begin
      vref_out     <= 1'b1;
      vref_oe_b    <= control_reg[ugc_pkg::CTL_DETACH];
      usb_clk_en   <= clk_run;
      xcvr_en      <= ctl_on;
      ctrl_rst_b   <= ctl_on;
      resume_drive <= (link_next == ugc_pkg::UGC_LINK_RESUME);
    end
  end

endmodule

`default_nettype wire

// File: sim/ugc_global_ctrl_props.sv
// Purpose: Port-level assertions for the USB global control block
// Assumes: Control and priority writes reach their outputs two edges later
// Notes:   Bound to ugc_global_ctrl from the testbench top file
`default_nettype none

module ugc_global_ctrl_chk #(
  parameter int RESUME_CYC = 10
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       vref_out,
  input wire logic       vref_oe_b,
  input wire logic       usb_clk_en,
  input wire logic       xcvr_en,
  input wire logic       ctrl_rst_b,
  input wire logic       resume_drive,
  input wire logic       usb_irq,
  input wire logic [1:0] usb_prio_level
);
  logic        wr_ctl;
  logic        wr_pri;
  logic [31:0] drive_cnt_reg;

  assign wr_ctl = reg_wr && (reg_addr == ugc_pkg::OFS_CONTROL);
  assign wr_pri = reg_wr && (reg_addr == ugc_pkg::OFS_PRIO);

  // Length of the current upstream resume burst; the edge leaving the state adds one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_cnt_reg <= 32'h0;
    end else if (resume_drive) begin
      drive_cnt_reg <= drive_cnt_reg + 32'h1;
    end else begin
      drive_cnt_reg <= 32'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_detach_float: assert property (
    wr_ctl |-> ##2 vref_oe_b == $past(reg_wdata[4], 2))
    else $error("reference output enable does not follow detach bit");
  chk_attach_drive: assert property (
    wr_ctl && !reg_wdata[4] |-> ##2 (!vref_oe_b && vref_out))
    else $error("reference output not driven high after attach");
  chk_prio_level: assert property (
    wr_pri ##1 !wr_pri [*2] |-> usb_prio_level == $past(reg_wdata[1:0], 2))
    else $error("priority level does not match priority bits");
  chk_enable_outputs: assert property (
    wr_ctl |-> ##2 (xcvr_en == $past(reg_wdata[7], 2)) && (ctrl_rst_b == xcvr_en))
    else $error("transceiver or controller reset wrong after enable write");
  chk_clock_gate: assert property (
    wr_ctl |-> ##2 usb_clk_en == ($past(reg_wdata[7], 2) && !$past(reg_wdata[6], 2)))
    else $error("controller clock enable wrong after control write");
  chk_disable_quiet: assert property (
    wr_ctl && !reg_wdata[7] |-> ##3 !usb_irq [*2])
    else $error("interrupt still raised after controller disable");
  chk_resume_length: assert property (
    $fell(resume_drive) |-> drive_cnt_reg == RESUME_CYC + 1)
    else $error("upstream resume burst has wrong length");
  chk_resume_clocks: assert property (
    $rose(resume_drive) |-> $past(usb_clk_en) && xcvr_en)
    else $error("upstream resume started with clocks stopped");
  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer cycle");

  cover property ($rose(resume_drive));
  cover property ($rose(vref_oe_b));
  cover property ($rose(usb_irq));
endmodule

`default_nettype wire

// File: sim/ugc_host_model.sv
// Purpose: Host side of the bus, sending events and holding the line state
// Assumes: One-cycle event pulses on the controller clock
// Notes:   Endpoint 2 starts isochronous; the line starts busy
`default_nettype none

module ugc_host_model (
  input  wire logic       clk,
  output var  logic [6:0] ev_in_acked,
  output var  logic [6:0] ev_out_bank0,
  output var  logic [6:0] ev_out_bank1,
  output var  logic [6:0] ev_setup,
  output var  logic [6:0] ev_stall_sent,
  output var  logic [6:0] ep_is_iso,
  output var  logic       ev_sof,
  output var  logic       ev_bus_reset_end,
  output var  logic       line_idle_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ev_in_acked      = 7'h00;
    ev_out_bank0     = 7'h00;
    ev_out_bank1     = 7'h00;
    ev_setup         = 7'h00;
    ev_stall_sent    = 7'h00;
    ep_is_iso        = 7'h04;
    ev_sof           = 1'b0;
    ev_bus_reset_end = 1'b0;
    line_idle_pin    = 1'b0;
  end

  // Kinds: 0 in ack, 1 bank0, 2 bank1, 3 setup, 4 stall, 5 frame, else bus reset end
  task automatic pulse(input int kind, input int ep);
    logic [6:0] m;
    m = 7'h01 << ep;
    @(posedge clk);
    case (kind)
      0: ev_in_acked <= m;
      1: ev_out_bank0 <= m;
      2: ev_out_bank1 <= m;
      3: ev_setup <= m;
      4: ev_stall_sent <= m;
      5: ev_sof <= 1'b1;
      default: ev_bus_reset_end <= 1'b1;
    endcase
    @(posedge clk);
    ev_in_acked      <= 7'h00;
    ev_out_bank0     <= 7'h00;
    ev_out_bank1     <= 7'h00;
    ev_setup         <= 7'h00;
    ev_stall_sent    <= 7'h00;
    ev_sof           <= 1'b0;
    ev_bus_reset_end <= 1'b0;
  endtask

  task automatic set_iso(input logic [6:0] m);
    @(posedge clk);
    ep_is_iso <= m;
  endtask

  task automatic set_line(input logic idle);
    @(posedge clk);
    line_idle_pin <= idle;
  endtask
endmodule

`default_nettype wire

// File: sim/usb_global_control_irq_test.sv
// Purpose: Register-level tests of the USB global control block
// Assumes: Short suspend, wakeup and resume counts for simulation
// Notes:   Host events come from ugc_host_model
`default_nettype none

module usb_global_control_irq_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] CTL = ugc_pkg::OFS_CONTROL;
  localparam logic [7:0] FLG = ugc_pkg::OFS_FLAGS;

  logic       clk, rst_b, reg_wr, reg_rd, vref_out, vref_oe_b, usb_clk_en, xcvr_en;
  logic       ctrl_rst_b, resume_drive, usb_irq, ev_sof, ev_bus_reset_end, line_idle_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [6:0] ev_in_acked, ev_out_bank0, ev_out_bank1, ev_setup, ev_stall_sent, ep_is_iso;
  logic [1:0] usb_prio_level;
  logic [7:0] ep_bit [5];
  int         err_total, tests_run;

  ugc_global_ctrl #(.IDLE_CYC(20), .SUSP_CYC(30),
    .RESUME_CYC(10)) ugc_global_ctrl_inst (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ev_in_acked(ev_in_acked), .ev_out_bank0(ev_out_bank0), .ev_out_bank1(ev_out_bank1),
    .ev_setup(ev_setup), .ev_stall_sent(ev_stall_sent), .ep_is_iso(ep_is_iso),
    .ev_sof(ev_sof), .ev_bus_reset_end(ev_bus_reset_end), .line_idle_pin(line_idle_pin),
    .vref_out(vref_out), .vref_oe_b(vref_oe_b), .usb_clk_en(usb_clk_en), .xcvr_en(xcvr_en),
    .ctrl_rst_b(ctrl_rst_b), .resume_drive(resume_drive), .usb_irq(usb_irq),
    .usb_prio_level(usb_prio_level));

  ugc_host_model ugc_host_model_inst (.clk(clk), .ev_in_acked(ev_in_acked),
    .ev_out_bank0(ev_out_bank0), .ev_out_bank1(ev_out_bank1), .ev_setup(ev_setup),
    .ev_stall_sent(ev_stall_sent), .ep_is_iso(ep_is_iso), .ev_sof(ev_sof),
    .ev_bus_reset_end(ev_bus_reset_end), .line_idle_pin(line_idle_pin));

  always #4 clk = ~clk;

  task automatic end_sim;
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wait_drive(input logic lvl);
    int i;
    i = 0;
    while (resume_drive !== lvl && i < 200) begin
      @(negedge clk);
      i++;
    end
  endtask

  initial begin
    clk = 1'b0; rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 8'h00; reg_wdata = 8'h00; err_total = 0; tests_run = 0;
    ep_bit = '{8'h01, 8'h02, 8'h40, 8'h04, 8'h08};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(CTL, 8'h00);
    check({6'h00, vref_out, vref_oe_b}, 8'h02);
    wr(CTL, 8'h88);
    rd(CTL, 8'h80);
    check({5'h00, xcvr_en, ctrl_rst_b, usb_clk_en}, 8'h07);
    wr(CTL, 8'hc0);
    settle(2);
    check({7'h00, usb_clk_en}, 8'h00);
    wr(CTL, 8'h90);
    settle(2);
    check({7'h00, vref_oe_b}, 8'h01);
    wr(CTL, 8'h80);
    settle(2);
    check({6'h00, vref_out, vref_oe_b}, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(ugc_pkg::OFS_PRIO, i[7:0]);
      settle(2);
      check({6'h00, usb_prio_level}, i[7:0]);
    end
    wr(ugc_pkg::OFS_FLAG_EN, 8'h39);
    wr(ugc_pkg::OFS_EP_EN, 8'h7f);
    wr(FLG, 8'hff);
    rd(FLG, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'hc7, 8'h00);
    ugc_host_model_inst.pulse(5, 0);
    rd(FLG, 8'h08);
    check({7'h00, usb_irq}, 8'h01);
    wr(FLG, 8'h00);
    settle(2);
    check({7'h00, usb_irq}, 8'h00);
    wr(CTL, 8'h83);
    ugc_host_model_inst.pulse(6, 0);
    rd(FLG, 8'h10);
    rd(CTL, 8'h80);
    wr(FLG, 8'h00);
    for (int k = 0; k < 5; k++) begin
      ugc_host_model_inst.pulse(k, 4);
      rd(8'hc4, ep_bit[k]);
      wr(8'hc4, 8'h00);
    end
    ugc_host_model_inst.pulse(4, 4);
    ugc_host_model_inst.pulse(3, 4);
    rd(8'hc4, 8'h04);
    wr(8'hc4, 8'h00);
    ugc_host_model_inst.pulse(2, 0);
    rd(8'hc0, 8'h00);
    ugc_host_model_inst.pulse(4, 2);
    rd(8'hc2, 8'h00);
    ugc_host_model_inst.set_iso(7'h00);
    ugc_host_model_inst.pulse(4, 2);
    rd(8'hc2, 8'h08);
    wr(8'hc2, 8'h00);
    ugc_host_model_inst.pulse(0, 1);
    rd(8'hc1, 8'h01);
    check({7'h00, usb_irq}, 8'h01);
    wr(8'hc1, 8'h00);
    // Idle line: suspend must not come early
    ugc_host_model_inst.set_line(1'b1);
    settle(10);
    rd(FLG, 8'h00);
    settle(20);
    rd(FLG, 8'h01);
    check({7'h00, usb_irq}, 8'h01);
    wr(CTL, 8'ha0);
    settle(40);
    check({7'h00, resume_drive}, 8'h00);
    wr(CTL, 8'h80);
    wr(FLG, 8'h00);
    wr(CTL, 8'ha4);
    wait_drive(1'b1);
    check({7'h00, resume_drive}, 8'h01);
    rd(CTL, 8'hac);
    wait_drive(1'b0);
    rd(CTL, 8'ha4);
    settle(40);
    wr(CTL, 8'hc4);
    wr(FLG, 8'h00);
    ugc_host_model_inst.set_line(1'b0);
    settle(6);
    rd(FLG, 8'h20);
    wr(CTL, 8'h80);
    ugc_host_model_inst.pulse(5, 0);
    wr(CTL, 8'h00);
    wr(CTL, 8'h80);
    rd(FLG, 8'h00);
    check({7'h00, usb_irq}, 8'h00);
    end_sim;
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    end_sim;
  end
endmodule

bind ugc_global_ctrl ugc_global_ctrl_chk #(.RESUME_CYC(RESUME_CYC)) ugc_global_ctrl_chk_inst (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vref_out(vref_out), .vref_oe_b(vref_oe_b),
  .usb_clk_en(usb_clk_en), .xcvr_en(xcvr_en), .ctrl_rst_b(ctrl_rst_b),
  .resume_drive(resume_drive), .usb_irq(usb_irq), .usb_prio_level(usb_prio_level));

`default_nettype wire
